// *** include/vcache_regs.svh ***
// Timing and size constants for the virtual-cache miss and alias control.
// Assumes inclusion by bare name from the alias check and miss control files.
`ifndef VCACHE_REGS_SVH
`define VCACHE_REGS_SVH

// Words per cache line filled or flushed
`define VC_LINE_WORDS 8
// Doubleword entries in the write-through write buffer
`define VC_WBUF_ENTRIES 4
// Clocks bus-drive enable leads the stall release
`define VC_IOE_LEAD 1
// Physical address width compared by the alias check
`define VC_PA_W 36

`endif

// *** include/vcache_pkg.sv ***
// Types shared by the miss control and snoop filter.
// Assumes nothing of its surroundings; compiled before all design files.
package vcache_pkg;

  // ****************************************
  // Miss sequencer states, Gray along the usual path
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CHECK   = 4'h1,
    ST_FETCH   = 4'h3,
    ST_DELIVER = 4'h2,
    ST_RELEASE = 4'h6,
    ST_WRITE   = 4'h7,
    ST_DIRTY   = 4'h5,
    ST_COPY    = 4'h4,
    ST_WTFULL  = 4'h9
  } state_t;

  // System bus transaction kinds
  typedef enum logic [2:0] {
    TX_READ   = 3'h0,
    TX_WRITE  = 3'h1,
    TX_CRD    = 3'h2,
    TX_CRDINV = 3'h3,
    TX_CWRINV = 3'h4,
    TX_CINV   = 3'h5
  } bus_txn_t;

  // Active-high byte lanes from address and size; byte 0 sits on lane 3
  function automatic logic [3:0] byte_lanes(input logic [1:0] lo, input logic [1:0] size);
    logic [3:0] l;
    l = 4'hf;
    case (size)
      2'h0:    l = 4'h8 >> lo;
      2'h1:    l = lo[1] ? 4'h3 : 4'hc;
      default: l = 4'hf;
    endcase
    return l;
  endfunction : byte_lanes

endpackage : vcache_pkg

// *** hw/alias_check.sv ***
// Alias detector: compares the physical address of a missing access with
// the physical tag selected by the cache index. Assumes the tag array
// presents the selected entry in the same cycle as the miss.
`timescale 1ns/1ps
`include "vcache_regs.svh"
module alias_check #(
  parameter int unsigned PA_W = `VC_PA_W
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  // Compare request
  input  wire logic            check_en,
  input  wire logic            mmu_enable_bit,
  input  wire logic [PA_W-1:0] miss_phys_addr,
  input  wire logic [PA_W-1:0] sel_ptag,
  input  wire logic            sel_ptag_valid,
  // Result, held until the next check
  output logic                 alias_hit
);

  // ****************************************
  // Compare on every miss
  // ****************************************
  // Without translation no two virtual names can share a frame
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alias_hit <= 1'b0;
    end else if (check_en) begin
      alias_hit <= mmu_enable_bit && sel_ptag_valid && (miss_phys_addr == sel_ptag);
    end
  end

  property p_no_alias_unmapped;
    @(posedge ref_clk) disable iff (!arst_n)
      (check_en && !mmu_enable_bit) |=> !alias_hit;
  endproperty
  a_no_alias_unmapped: assert property (p_no_alias_unmapped)
    else $error("alias flagged with translation disabled");

endmodule : alias_check

// *** hw/snoop_filter.sv ***
// Bus snoop filter: picks the coherent transactions looked up in the
// physical tags, answers shared at A+2 in write-through mode and invalidates on coherent kills.
// Assumes the tag lookup result arrives one clock after the address cycle.
`timescale 1ns/1ps
module snoop_filter (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // Mode and bus address cycle
  input  wire logic                 cache_mode_wt,
  input  wire logic                 bus_addr_valid,
  input  wire vcache_pkg::bus_txn_t bus_txn_type,
  input  wire logic                 snoop_line_valid,
  input  wire vcache_pkg::bus_txn_t own_txn_type,
  // Snoop answers
  output logic                      snoop_lookup,
  output logic                      shared_line_indicator_n,
  output logic                      snoop_invalidate,
  output logic                      own_txn_allowed
);

  vcache_pkg::bus_txn_t type1_r;

  // Plain reads and writes never touch the tags, in either mode
  function automatic logic snooped(input vcache_pkg::bus_txn_t t);
    return (t == vcache_pkg::TX_CRD) || (t == vcache_pkg::TX_CRDINV) ||
           (t == vcache_pkg::TX_CWRINV) || (t == vcache_pkg::TX_CINV);
  endfunction : snooped

  // ****************************************
  // Address cycle: A+1 lookup
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      snoop_lookup <= 1'b0;
      type1_r      <= vcache_pkg::TX_READ;
    end else begin
      snoop_lookup <= bus_addr_valid && snooped(bus_txn_type);
      type1_r      <= bus_txn_type;
    end
  end

  // A+2: shared answer and tag kill
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shared_line_indicator_n <= 1'b1;
      snoop_invalidate        <= 1'b0;
    end else begin
      shared_line_indicator_n <= !(snoop_lookup && snoop_line_valid && cache_mode_wt &&
                                   type1_r == vcache_pkg::TX_CRD);
      snoop_invalidate <= snoop_lookup && snoop_line_valid &&
                          type1_r != vcache_pkg::TX_CRD;
    end
  end

  // Write-through mode keeps to uncoherent reads, plain writes and write-invalidates
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      own_txn_allowed <= 1'b1;
    end else begin
      own_txn_allowed <= !(cache_mode_wt && snooped(own_txn_type) &&
                           own_txn_type != vcache_pkg::TX_CWRINV);
    end
  end

  property p_plain_not_snooped;
    @(posedge ref_clk) disable iff (!arst_n)
      (bus_addr_valid && !snooped(bus_txn_type)) |=> !snoop_lookup;
  endproperty
  a_plain_not_snooped: assert property (p_plain_not_snooped)
    else $error("plain transaction was snooped");

  property p_wt_no_coherent_origin;
    @(posedge ref_clk) disable iff (!arst_n)
      (cache_mode_wt && own_txn_type == vcache_pkg::TX_CINV) |=> !own_txn_allowed;
  endproperty
  a_wt_no_coherent_origin: assert property (p_wt_no_coherent_origin)
    else $error("write-through allowed a coherent origin");

  property p_shared_at_a2;
    @(posedge ref_clk) disable iff (!arst_n)
      (bus_addr_valid && bus_txn_type == vcache_pkg::TX_CRD && cache_mode_wt)
        ##1 (snoop_line_valid && cache_mode_wt) |=> !shared_line_indicator_n;
  endproperty
  a_shared_at_a2: assert property (p_shared_at_a2)
    else $error("shared not answered at A+2");

endmodule : snoop_filter

// *** hw/miss_alias_ctrl.sv ***
// Virtual-cache miss sequencer with alias handling and snoop selection.
// Assumes the processor holds its request until proc_stall falls, and
// that the fetch engine and both buffers obey the strobes given here.
`timescale 1ns/1ps
`include "vcache_regs.svh"

// What this block does
// - Copy-back snoops four coherent kinds only
// - Write-through never originates coherent reads, invalidates
// - Alias check every miss, only with translation
// - Physical address equal to selected tag aliases
// - Read alias: retag, drop fetch, serve cache
// - Copy-back write alias: retag, mark, write
// - Write-through write miss: memory only, alias invalidates
// - Stall while request cannot be serviced
// - Data strobe pulses only under stall
// - Bus-drive enable low takes processor off bus
// - Read output enable low on cache reads
// - Four byte write enables; reads full word
// - Read miss: stall, release bus, fill, strobe
// - Reassert bus-drive before releasing stall
// - Same read miss in both modes
// - Write-through write miss goes to write buffer
// - Stall write-through only while buffer full
// - Clean copy-back write: refill, then write
// - Dirty line to write buffer during fetch
// - Copy read buffer in, then write data
// - Write-through shared at A+2; invalidate on coherent kills
module miss_alias_ctrl #(
  parameter int unsigned PA_W         = `VC_PA_W,
  parameter int unsigned LINE_WORDS   = `VC_LINE_WORDS,
  parameter int unsigned WBUF_ENTRIES = `VC_WBUF_ENTRIES,
  parameter int unsigned IOE_LEAD     = `VC_IOE_LEAD,
  parameter int unsigned WCW          = $clog2(WBUF_ENTRIES + 1)
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // Configuration
  input  wire logic                 cache_mode_wt,
  input  wire logic                 mmu_enable_bit,
  // Processor request
  input  wire logic                 req_valid,
  input  wire logic                 req_write,
  input  wire logic                 req_hit,
  input  wire logic [1:0]           req_addr_lo,
  input  wire logic [1:0]           req_size,
  input  wire logic [PA_W-1:0]      req_phys_addr,
  input  wire logic                 walk_busy,
  // Selected tag entry
  input  wire logic [PA_W-1:0]      sel_ptag,
  input  wire logic                 sel_ptag_valid,
  input  wire logic                 line_modified,
  // Memory fetch and buffers
  input  wire logic                 fetch_word_valid,
  input  wire logic [WCW-1:0]       wbuf_count,
  output logic                      fetch_req,
  output logic                      wbuf_push,
  output logic                      wbuf_line_load,
  output logic                      rbuf_pop,
  // Processor control
  output logic                      proc_stall,
  output logic                      proc_data_strobe,
  output logic                      proc_bus_drive_enable,
  // Cache RAM control
  output logic [3:0]                cram_byte_write_en_n,
  output logic                      cram_read_out_en_n,
  // Tag updates
  output logic                      tag_rewrite,
  output logic                      tag_set_modified,
  output logic                      tag_invalidate,
  // Bus snooping
  input  wire logic                 bus_addr_valid,
  input  wire vcache_pkg::bus_txn_t bus_txn_type,
  input  wire logic                 snoop_line_valid,
  input  wire vcache_pkg::bus_txn_t own_txn_type,
  output logic                      snoop_lookup,
  output logic                      shared_line_indicator_n,
  output logic                      snoop_invalidate,
  output logic                      own_txn_allowed
);

  localparam int unsigned CW = $clog2(LINE_WORDS + 1);
  localparam logic [CW-1:0] LAST_W = CW'(LINE_WORDS - 1);
  localparam logic [CW-1:0] FULL_W = CW'(LINE_WORDS);
  localparam logic [CW-1:0] LEAD_W = CW'(IOE_LEAD - 1);
  localparam logic [WCW-1:0] WB_FULL = WCW'(WBUF_ENTRIES);

  vcache_pkg::state_t st_r, st_nxt;
  logic [CW-1:0]  cnt_r, cnt_nxt, fcnt_r;
  logic           wr_r, wt_r, mod_r, alias_hit, miss_take, wb_full;
  logic [3:0]     lanes_r;
  logic           stall_nxt, strobe_nxt, ioe_nxt, cram_read_out_en_n_nxt;
  logic [3:0]     cram_byte_write_en_n_nxt;
  logic           fetch_nxt, push_nxt, load_nxt, pop_nxt;
  logic           rewrite_nxt, setmod_nxt, inval_nxt;

  // ****************************************
  // Alias check and snoop filter
  // ****************************************
  assign miss_take = (st_r == vcache_pkg::ST_IDLE) && req_valid && !req_hit && !walk_busy;
  assign wb_full   = (wbuf_count >= WB_FULL);

  alias_check #(.PA_W(PA_W)) u_alias (
    .ref_clk        (ref_clk),
    .arst_n         (arst_n),
    .check_en       (miss_take),
    .mmu_enable_bit (mmu_enable_bit),
    .miss_phys_addr (req_phys_addr),
    .sel_ptag       (sel_ptag),
    .sel_ptag_valid (sel_ptag_valid),
    .alias_hit      (alias_hit)
  );

  snoop_filter u_snoop (
    .ref_clk                 (ref_clk),
    .arst_n                  (arst_n),
    .cache_mode_wt           (cache_mode_wt),
    .bus_addr_valid          (bus_addr_valid),
    .bus_txn_type            (bus_txn_type),
    .snoop_line_valid        (snoop_line_valid),
    .own_txn_type            (own_txn_type),
    .snoop_lookup            (snoop_lookup),
    .shared_line_indicator_n (shared_line_indicator_n),
    .snoop_invalidate        (snoop_invalidate),
    .own_txn_allowed         (own_txn_allowed)
  );

  // ****************************************
  // Request capture
  // ****************************************
  // Mode is frozen per miss so a mode change cannot split a sequence
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_r    <= 1'b0;
      wt_r    <= 1'b0;
      mod_r   <= 1'b0;
      lanes_r <= 4'h0;
    end else if (miss_take) begin
      wr_r    <= req_write;
      wt_r    <= cache_mode_wt;
      mod_r   <= line_modified;
      lanes_r <= vcache_pkg::byte_lanes(req_addr_lo, req_size);
    end
  end

  // Words landed in the read buffer during a dirty replacement
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fcnt_r <= '0;
    end else if (st_r == vcache_pkg::ST_CHECK) begin
      fcnt_r <= '0;
    end else if (st_r == vcache_pkg::ST_DIRTY && fetch_word_valid && fcnt_r != FULL_W) begin
      fcnt_r <= fcnt_r + CW'(1);
    end
  end

  // ****************************************
  // Sequencer decisions
  // ****************************************
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    stall_nxt   = proc_stall;
    ioe_nxt     = proc_bus_drive_enable;
    strobe_nxt  = 1'b0;
    cram_read_out_en_n_nxt  = 1'b1;
    cram_byte_write_en_n_nxt  = 4'hf;
    fetch_nxt   = 1'b0;
    push_nxt    = 1'b0;
    load_nxt    = 1'b0;
    pop_nxt     = 1'b0;
    rewrite_nxt = 1'b0;
    setmod_nxt  = 1'b0;
    inval_nxt   = 1'b0;
    case (st_r)
      vcache_pkg::ST_IDLE: begin
        ioe_nxt   = 1'b1;
        stall_nxt = walk_busy;
        if (miss_take) begin
          st_nxt    = vcache_pkg::ST_CHECK;
          stall_nxt = !(req_write && cache_mode_wt);
        end
      end
      vcache_pkg::ST_CHECK: begin
        cnt_nxt = '0;
        if (!wr_r) begin
          if (alias_hit) begin
            rewrite_nxt = 1'b1;
            cram_read_out_en_n_nxt  = 1'b0;
            strobe_nxt  = 1'b1;
            st_nxt      = vcache_pkg::ST_RELEASE;
          end else begin
            ioe_nxt   = 1'b0;
            fetch_nxt = 1'b1;
            st_nxt    = vcache_pkg::ST_FETCH;
          end
        end else if (wt_r) begin
          if (wb_full) begin
            stall_nxt = 1'b1;
            st_nxt    = vcache_pkg::ST_WTFULL;
          end else begin
            push_nxt  = 1'b1;
            inval_nxt = alias_hit;
            st_nxt    = vcache_pkg::ST_IDLE;
          end
        end else if (alias_hit) begin
          rewrite_nxt = 1'b1;
          setmod_nxt  = !mod_r;
          cram_byte_write_en_n_nxt  = ~lanes_r;
          st_nxt      = vcache_pkg::ST_RELEASE;
        end else begin
          ioe_nxt   = 1'b0;
          fetch_nxt = 1'b1;
          st_nxt    = mod_r ? vcache_pkg::ST_DIRTY : vcache_pkg::ST_FETCH;
        end
      end
      vcache_pkg::ST_FETCH: begin
        if (fetch_word_valid) begin
          cram_byte_write_en_n_nxt = 4'h0;
          cnt_nxt    = cnt_r + CW'(1);
          if (cnt_r == LAST_W) begin
            st_nxt  = wr_r ? vcache_pkg::ST_WRITE : vcache_pkg::ST_DELIVER;
            ioe_nxt = wr_r;
          end
        end
      end
      vcache_pkg::ST_DELIVER: begin
        cram_read_out_en_n_nxt = 1'b0;
        strobe_nxt = 1'b1;
        ioe_nxt    = 1'b1;
        cnt_nxt    = '0;
        st_nxt     = vcache_pkg::ST_RELEASE;
      end
      vcache_pkg::ST_DIRTY: begin
        // Readout and refill overlap; copy waits for both to finish
        if (cnt_r != FULL_W) begin
          cram_read_out_en_n_nxt = 1'b0;
          load_nxt   = 1'b1;
          cnt_nxt    = cnt_r + CW'(1);
        end else if (fcnt_r == FULL_W) begin
          cnt_nxt = '0;
          st_nxt  = vcache_pkg::ST_COPY;
        end
      end
      vcache_pkg::ST_COPY: begin
        pop_nxt    = 1'b1;
        cram_byte_write_en_n_nxt = 4'h0;
        cnt_nxt    = cnt_r + CW'(1);
        if (cnt_r == LAST_W) begin
          ioe_nxt = 1'b1;
          st_nxt  = vcache_pkg::ST_WRITE;
        end
      end
      vcache_pkg::ST_WRITE: begin
        cram_byte_write_en_n_nxt = ~lanes_r;
        cnt_nxt    = '0;
        st_nxt     = vcache_pkg::ST_RELEASE;
      end
      vcache_pkg::ST_RELEASE: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_r >= LEAD_W) begin
          stall_nxt = 1'b0;
          st_nxt    = vcache_pkg::ST_IDLE;
        end
      end
      vcache_pkg::ST_WTFULL: begin
        if (!wb_full) begin
          push_nxt  = 1'b1;
          inval_nxt = alias_hit;
          stall_nxt = 1'b0;
          st_nxt    = vcache_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt    = vcache_pkg::ST_IDLE;
        stall_nxt = 1'b0;
        ioe_nxt   = 1'b1;
      end
    endcase
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r  <= vcache_pkg::ST_IDLE;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Processor and RAM strobes, all registered to keep pin timing clean
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      proc_stall            <= 1'b0;
      proc_data_strobe      <= 1'b0;
      proc_bus_drive_enable <= 1'b1;
      cram_byte_write_en_n  <= 4'hf;
      cram_read_out_en_n    <= 1'b1;
    end else begin
      proc_stall            <= stall_nxt;
      proc_data_strobe      <= strobe_nxt;
      proc_bus_drive_enable <= ioe_nxt;
      cram_byte_write_en_n  <= cram_byte_write_en_n_nxt;
      cram_read_out_en_n    <= cram_read_out_en_n_nxt;
    end
  end

  // Buffer, fetch and tag strobes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_req        <= 1'b0;
      wbuf_push        <= 1'b0;
      wbuf_line_load   <= 1'b0;
      rbuf_pop         <= 1'b0;
      tag_rewrite      <= 1'b0;
      tag_set_modified <= 1'b0;
      tag_invalidate   <= 1'b0;
    end else begin
      fetch_req        <= fetch_nxt;
      wbuf_push        <= push_nxt;
      wbuf_line_load   <= load_nxt;
      rbuf_pop         <= pop_nxt;
      tag_rewrite      <= rewrite_nxt;
      tag_set_modified <= setmod_nxt;
      tag_invalidate   <= inval_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_strobe_under_stall;
    @(posedge ref_clk) disable iff (!arst_n)
      proc_data_strobe |-> proc_stall;
  endproperty
  a_strobe_under_stall: assert property (p_strobe_under_stall)
    else $error("data strobe without stall");

  property p_off_bus_stalled;
    @(posedge ref_clk) disable iff (!arst_n)
      !proc_bus_drive_enable |-> proc_stall;
  endproperty
  a_off_bus_stalled: assert property (p_off_bus_stalled)
    else $error("processor off bus while running");

  property p_ioe_leads_release;
    @(posedge ref_clk) disable iff (!arst_n)
      $fell(proc_stall) |-> $past(proc_bus_drive_enable) && proc_bus_drive_enable;
  endproperty
  a_ioe_leads_release: assert property (p_ioe_leads_release)
    else $error("stall released before bus-drive enable");

  property p_fill_word;
    @(posedge ref_clk) disable iff (!arst_n)
      (st_r == vcache_pkg::ST_FETCH && fetch_word_valid) |=>
        cram_byte_write_en_n == 4'h0 &&
        proc_bus_drive_enable == (wr_r && st_r == vcache_pkg::ST_WRITE);
  endproperty
  a_fill_word: assert property (p_fill_word)
    else $error("fetched word not written to cache");

  property p_wt_inval_alias;
    @(posedge ref_clk) disable iff (!arst_n)
      (st_r == vcache_pkg::ST_CHECK && wr_r && wt_r && !wb_full) |=>
        wbuf_push && (tag_invalidate == $past(alias_hit)) && !proc_stall;
  endproperty
  a_wt_inval_alias: assert property (p_wt_inval_alias)
    else $error("write-through miss mishandled");

  property p_wt_full_stall;
    @(posedge ref_clk) disable iff (!arst_n)
      (st_r == vcache_pkg::ST_WTFULL && wb_full) |=> proc_stall && !wbuf_push;
  endproperty
  a_wt_full_stall: assert property (p_wt_full_stall)
    else $error("stall dropped while buffer full");

  property p_read_alias;
    @(posedge ref_clk) disable iff (!arst_n)
      (st_r == vcache_pkg::ST_CHECK && !wr_r && alias_hit) |=>
        tag_rewrite && !cram_read_out_en_n && proc_data_strobe && !fetch_req;
  endproperty
  a_read_alias: assert property (p_read_alias)
    else $error("read alias not served from cache");

  property p_cb_alias_mark;
    @(posedge ref_clk) disable iff (!arst_n)
      tag_set_modified |-> tag_rewrite && cram_byte_write_en_n != 4'hf;
  endproperty
  a_cb_alias_mark: assert property (p_cb_alias_mark)
    else $error("modified set without retag and write");

  property p_dirty_readout;
    @(posedge ref_clk) disable iff (!arst_n)
      wbuf_line_load |-> !cram_read_out_en_n && !proc_bus_drive_enable;
  endproperty
  a_dirty_readout: assert property (p_dirty_readout)
    else $error("dirty readout without read enable");

endmodule : miss_alias_ctrl

// *** test/fetch_model.sv ***
// Far-side fetch engine model: answers each line fetch with eight words.
// Assumes fetch_req is a one-clock pulse from the miss sequencer.
`timescale 1ns/1ps
module fetch_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // Fetch request and word delivery
  input  wire logic fetch_req,
  output logic      fetch_word_valid
);
  logic [4:0] left_r;
  // One word every other clock, so the memory is slower than the cache
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      left_r           <= 5'h0;
      fetch_word_valid <= 1'b0;
    end else begin
      if (fetch_req) left_r <= 5'h10;
      else if (left_r != 5'h0) left_r <= left_r - 5'h1;
      fetch_word_valid <= left_r[0];
    end
  end
endmodule : fetch_model

// *** test/miss_alias_ctrl_bench.sv ***
// Bench for the miss and alias controller: misses, aliases, buffer stall, snoops.
// Assumes fetch_model answers every fetch_req with a full line.
`timescale 1ns/1ps
module miss_alias_ctrl_bench;
  // ****
  // Signals and instances
  // ****
  logic        ref_clk = 1'b0, arst_n = 1'b0, cache_mode_wt = 1'b0, mmu_enable_bit = 1'b1;
  logic        req_valid = 1'b0, req_write = 1'b0, req_hit = 1'b0, walk_busy = 1'b0;
  logic [1:0]  req_addr_lo = 2'h1, req_size = 2'h0;
  logic [35:0] req_phys_addr = 36'h0, sel_ptag = 36'h1;
  logic        sel_ptag_valid = 1'b1, line_modified = 1'b0, snoop_line_valid = 1'b1;
  logic        bus_addr_valid = 1'b0, fetch_word_valid;
  logic [2:0]  wbuf_count = 3'h0;
  vcache_pkg::bus_txn_t bus_txn_type = vcache_pkg::TX_READ, own_txn_type = vcache_pkg::TX_READ;
  logic        fetch_req, wbuf_push, wbuf_line_load, rbuf_pop, proc_stall, proc_data_strobe;
  logic        proc_bus_drive_enable, cram_read_out_en_n, tag_rewrite, tag_set_modified;
  logic        tag_invalidate, snoop_lookup, shared_line_indicator_n, snoop_invalidate;
  logic        own_txn_allowed;
  logic [3:0]  cram_byte_write_en_n;
  int          fails = 0, tests_run = 0, cnt[13];
  always #5 ref_clk = ~ref_clk;
  miss_alias_ctrl miss_alias_ctrl_inst (.*);
  fetch_model fetch_model_inst (.ref_clk(ref_clk), .arst_n(arst_n), .fetch_req(fetch_req),
    .fetch_word_valid(fetch_word_valid));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (e !== g) begin
      fails++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // Tallies the outputs over one miss; slots: strobe, writes, reads, bus off,
  // retag, mark, kill, push, fetch, buffer moves, drive before release, lanes, stall
  task automatic run_op(input logic wr, input logic [35:0] pa);
    cnt = '{default: 0};
    cnt[10] = 1;
    cnt[11] = 15;
    @(negedge ref_clk);
    req_write = wr;
    req_phys_addr = pa;
    req_valid = 1'b1;
    for (int k = 0; k < 80; k++) begin
      @(negedge ref_clk);
      cnt[0] += proc_data_strobe;
      cnt[1] += cram_byte_write_en_n != 4'hf;
      cnt[2] += !cram_read_out_en_n;
      cnt[3] += !proc_bus_drive_enable;
      cnt[4] += tag_rewrite;
      cnt[5] += tag_set_modified;
      cnt[6] += tag_invalidate;
      cnt[7] += wbuf_push;
      cnt[8] += fetch_req;
      cnt[9] += wbuf_line_load + rbuf_pop;
      if (cram_byte_write_en_n != 4'hf) cnt[11] = cram_byte_write_en_n;
      if (proc_stall && k == 6) wbuf_count = 3'h3; // Drain frees one entry
      if ((cnt[12] && !proc_stall) || wbuf_push) break;
      cnt[12] = proc_stall ? 1 : cnt[12];
      cnt[10] = proc_bus_drive_enable;
    end
    req_valid = 1'b0;
    cnt[3] = cnt[3] != 0;
  endtask : run_op
  task automatic exp_cnt(input string n, input int e[13]);
    for (int i = 0; i < 13; i++) chk($sformatf("%s_%0d", n, i), e[i], cnt[i]);
    $display("Done %s", n);
  endtask : exp_cnt
  // ****
  // Scenarios
  // ****
  task automatic t_read();
    run_op(1'b0, 36'h0);
    exp_cnt("rd_cb", '{1, 8, 1, 1, 0, 0, 0, 0, 1, 0, 1, 0, 1});
    cache_mode_wt = 1'b1;
    run_op(1'b0, 36'h0);
    exp_cnt("rd_wt", '{1, 8, 1, 1, 0, 0, 0, 0, 1, 0, 1, 0, 1});
    cache_mode_wt = 1'b0;
    run_op(1'b0, 36'h1);
    exp_cnt("rd_alias", '{1, 0, 1, 0, 1, 0, 0, 0, 0, 0, 1, 15, 1});
    mmu_enable_bit = 1'b0;
    run_op(1'b0, 36'h1);
    exp_cnt("rd_nommu", '{1, 8, 1, 1, 0, 0, 0, 0, 1, 0, 1, 0, 1});
    mmu_enable_bit = 1'b1;
  endtask : t_read
  task automatic t_cb_write();
    run_op(1'b1, 36'h1);
    exp_cnt("cb_alias", '{0, 1, 0, 0, 1, 1, 0, 0, 0, 0, 1, 11, 1});
    req_size = 2'h1;
    req_addr_lo = 2'h2;
    run_op(1'b1, 36'h0);
    exp_cnt("cb_clean", '{0, 9, 0, 1, 0, 0, 0, 0, 1, 0, 1, 12, 1});
    req_size = 2'h3;
    line_modified = 1'b1;
    run_op(1'b1, 36'h0);
    exp_cnt("cb_dirty", '{0, 9, 8, 1, 0, 0, 0, 0, 1, 16, 1, 0, 1});
  endtask : t_cb_write
  task automatic t_wt_write();
    cache_mode_wt = 1'b1;
    wbuf_count = 3'h0;
    run_op(1'b1, 36'h1);
    exp_cnt("wt_alias", '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 1, 15, 0});
    wbuf_count = 3'h4;
    run_op(1'b1, 36'h0);
    exp_cnt("wt_full", '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 15, 1});
  endtask : t_wt_write
  // Table walk stalls without taking a miss; a hit stalls only while a walk is busy
  task automatic t_walk();
    @(negedge ref_clk);
    walk_busy = 1'b1;
    req_valid = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("walk_stall", 8'h1, proc_stall);
    walk_busy = 1'b0;
    req_hit = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("hit_run", 8'h0, proc_stall);
    req_valid = 1'b0;
    req_hit = 1'b0;
    $display("Done walk");
  endtask : t_walk
  task automatic t_snoop(input logic wt);
    cache_mode_wt = wt;
    for (int i = 0; i < 6; i++) begin
      @(negedge ref_clk);
      bus_txn_type = vcache_pkg::bus_txn_t'(i);
      own_txn_type = bus_txn_type;
      bus_addr_valid = 1'b1;
      @(negedge ref_clk);
      bus_addr_valid = 1'b0;
      chk("lookup", i >= 2, snoop_lookup);
      @(negedge ref_clk);
      chk("shared_n", !(wt && i == 2), shared_line_indicator_n);
      chk("kill", i >= 3, snoop_invalidate);
      chk("own", !(wt && (i == 2 || i == 3 || i == 5)), own_txn_allowed);
    end
    $display("Done snoop");
  endtask : t_snoop
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Main sequence; reset held two cycles, inputs move on the falling edge
  initial begin
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    chk("rst", 8'h3f, {proc_stall, proc_data_strobe, proc_bus_drive_enable,
      cram_read_out_en_n, cram_byte_write_en_n});
    t_read();
    t_cb_write();
    t_wt_write();
    t_walk();
    t_snoop(1'b0);
    t_snoop(1'b1);
    finish_test();
  end
  // Watchdog: all scenarios need well under 1000 clocks
  initial begin
    #20000;
    fails++;
    finish_test();
  end
endmodule : miss_alias_ctrl_bench
